// ===== shared/ifcap_cfg.svh
// constants for the interrupt and fault capture block
// assumes inclusion by the package and both ends
`ifndef IFCAP_CFG_SVH
`define IFCAP_CFG_SVH
`define IFCAP_N_USER 6
`define IFCAP_N_IOL 2
`define IFCAP_W 16
`define IFCAP_FLT_MEMBUS 7
`define IFCAP_FLT_SYSTEM_FAULT_IN 8
`define IFCAP_FLT_IOBUS 10
`define IFCAP_FLT_PARITY 13
`define IFCAP_FLT_DMA 14
`define IFCAP_FLT_CPU 15
`define IFCAP_PEND_PWR 15
`define IFCAP_PEND_USER0 0
`define IFCAP_PEND_IOL0 6
`define IFCAP_STAT_CONSOLE 3
`define IFCAP_N_SYNC 17
`define IFCAP_SYN_SYS 0
`define IFCAP_SYN_BTE 1
`define IFCAP_SYN_PAR 2
`define IFCAP_SYN_PROT 3
`define IFCAP_SYN_USR 4
`define IFCAP_SYN_IOL 10
`define IFCAP_SYN_PWR 12
`define IFCAP_SYN_CON 13
`define IFCAP_SYN_MASTER_RESET_N 14
`define IFCAP_SYN_TEST 15
`define IFCAP_SYN_EMU 16
`define IFCAP_DRV_EMU 14
`define IFCAP_SYNC_IDLE 17'h0c000
`define IFCAP_ZERO16 16'h0000
`define IFCAP_NONE 5'h10
`define IFCAP_REG_FAULT 2'h0
`define IFCAP_REG_PEND 2'h1
`define IFCAP_REG_MASK 2'h2
`define IFCAP_REG_STAT 2'h3
`endif

// ===== shared/ifcap_pkg.sv
// types for the interrupt and fault capture block
// assumes ifcap_cfg.svh on the include path
`include "ifcap_cfg.svh"
package ifcap_pkg;
  typedef logic [`IFCAP_W-1:0] ifcap_word_t;
  typedef logic [1:0] ifcap_addr_t;
  typedef logic [4:0] ifcap_level_t;
  typedef enum logic [1:0] {
    IFCAP_RUN = 2'b00,
    IFCAP_RESET = 2'b01,
    IFCAP_TEST = 2'b10
  } ifcap_mode_t;
endpackage

// ===== shared/ifcap_if.sv
// pins between the processor end and the system logic end
// assumes one shared clock
`timescale 1ns/10ps
interface ifcap_if;
  logic system_fault_in;
  logic bus_time_error_n;
  logic mem_parity_err_in;
  logic mem_protect_fault_in;
  logic [5:0] user_irq_n;
  logic [1:0] io_level_irq_n;
  logic power_fail_n;
  logic master_reset_n;
  logic console_in;
  logic test_n;
  logic emulation_mode_sel;
  logic io_cycle;
  logic own_bus;
  logic outputs_oe;
  logic processor_clock_out;
  modport dev (input system_fault_in, bus_time_error_n, mem_parity_err_in, mem_protect_fault_in,
    user_irq_n, io_level_irq_n, power_fail_n, master_reset_n, console_in, test_n,
    emulation_mode_sel, output io_cycle, own_bus, outputs_oe, processor_clock_out);
  modport sys (output system_fault_in, bus_time_error_n, mem_parity_err_in, mem_protect_fault_in,
    user_irq_n, io_level_irq_n, power_fail_n, master_reset_n, console_in, test_n,
    emulation_mode_sel, input io_cycle, own_bus, outputs_oe, processor_clock_out);
endinterface

// ===== design/ifcap_device.sv
// processor end: fault register, pending interrupts, mask, status
// assumes pins from the system end arrive asynchronously
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "ifcap_cfg.svh"
module ifcap_device (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ifcap_if.dev bus,
  input wire logic i_io_cycle,
  input wire logic i_own_bus,
  input wire ifcap_pkg::ifcap_addr_t i_addr,
  input wire ifcap_pkg::ifcap_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic [4:0] o_level,
  output logic o_irq,
  output logic o_maint_console
);
  import ifcap_pkg::*;
  localparam int NI = `IFCAP_N_SYNC;
  typedef struct packed {
    logic [NI-1:0] s1;
    logic [NI-1:0] s2;
    logic [NI-1:0] prev;
    ifcap_word_t fault;
    ifcap_word_t pend;
    ifcap_word_t mask;
    ifcap_word_t stat;
    ifcap_word_t rdata;
    ifcap_level_t level;
    logic irq;
    logic maint;
    logic io_cycle;
    logic own_bus;
    logic oe;
    logic clk_out;
  } ifcap_dev_state_t;
  ifcap_dev_state_t q;
  ifcap_dev_state_t next_q;
  logic [NI-1:0] raw;
  // ==========================================
  // priority encoder
  function automatic ifcap_level_t top_level(input ifcap_word_t req);
    ifcap_level_t r;
    r = `IFCAP_NONE;
    for (int k = 0; k < `IFCAP_W; k++) begin
      if (req[k]) begin
        r = 5'(k);
      end
    end
    return r;
  endfunction
  // ==========================================
  // synchronisers, inputs in active-high form except master_reset_n and test_n, which stay active-low
  always_comb begin
    raw = {bus.emulation_mode_sel, bus.test_n, bus.master_reset_n, bus.console_in, ~bus.power_fail_n,
      ~bus.io_level_irq_n, ~bus.user_irq_n, bus.mem_protect_fault_in, bus.mem_parity_err_in,
      ~bus.bus_time_error_n, bus.system_fault_in};
  end
  // ==========================================
  // fault, pending, mask and status update
  always_comb begin
    logic sys_f, bte, par, prot, pwr, con, master_reset_n_n, test_n, emu;
    logic [`IFCAP_N_USER-1:0] usr;
    logic [`IFCAP_N_IOL-1:0] iol;
    logic [`IFCAP_N_USER-1:0] usr_edge;
    logic [`IFCAP_N_IOL-1:0] iol_edge;
    ifcap_word_t hold;
    ifcap_word_t set_f;
    ifcap_word_t set_p;
    ifcap_word_t unmask;
    sys_f = q.s2[`IFCAP_SYN_SYS];
    bte = q.s2[`IFCAP_SYN_BTE];
    par = q.s2[`IFCAP_SYN_PAR];
    prot = q.s2[`IFCAP_SYN_PROT];
    usr = q.s2[`IFCAP_SYN_USR +: `IFCAP_N_USER];
    iol = q.s2[`IFCAP_SYN_IOL +: `IFCAP_N_IOL];
    pwr = q.s2[`IFCAP_SYN_PWR];
    con = q.s2[`IFCAP_SYN_CON];
    master_reset_n_n = q.s2[`IFCAP_SYN_MASTER_RESET_N];
    test_n = q.s2[`IFCAP_SYN_TEST];
    emu = q.s2[`IFCAP_SYN_EMU];
    usr_edge = usr & ~q.prev[`IFCAP_SYN_USR +: `IFCAP_N_USER];
    iol_edge = iol & ~q.prev[`IFCAP_SYN_IOL +: `IFCAP_N_IOL];
    set_f = `IFCAP_ZERO16;
    set_p = `IFCAP_ZERO16;
    hold = `IFCAP_ZERO16;
    // power fail bit passes regardless of mask
    unmask = ~q.mask;
    unmask[`IFCAP_PEND_PWR] = 1'b1;
    next_q = q;
    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.prev = q.s2;
    if (sys_f && !q.prev[`IFCAP_SYN_SYS]) begin
      set_f[`IFCAP_FLT_SYSTEM_FAULT_IN] = 1'b1;
    end
    if (bte) begin
      if (q.io_cycle) begin
        set_f[`IFCAP_FLT_IOBUS] = 1'b1;
      end else begin
        set_f[`IFCAP_FLT_MEMBUS] = 1'b1;
      end
    end
    if (par) begin
      set_f[`IFCAP_FLT_PARITY] = 1'b1;
    end
    if (prot) begin
      if (q.own_bus) begin
        set_f[`IFCAP_FLT_CPU] = 1'b1;
      end else begin
        set_f[`IFCAP_FLT_DMA] = 1'b1;
      end
    end
    hold = set_f;
    hold[`IFCAP_FLT_SYSTEM_FAULT_IN] = 1'b0;
    set_p[`IFCAP_PEND_USER0 +: `IFCAP_N_USER] = usr_edge;
    set_p[`IFCAP_PEND_IOL0 +: `IFCAP_N_IOL] = iol_edge;
    if (pwr) begin
      set_p[`IFCAP_PEND_PWR] = 1'b1;
    end
    // register writes, clears are write-one-to-clear, set wins
    if (i_wr) begin
      case (i_addr)
        `IFCAP_REG_FAULT: next_q.fault = q.fault & ~(i_wdata & ~hold);
        `IFCAP_REG_PEND: next_q.pend = q.pend & ~i_wdata;
        `IFCAP_REG_MASK: next_q.mask = i_wdata;
        `IFCAP_REG_STAT: next_q.stat = q.stat & ~i_wdata;
        default: next_q.mask = q.mask;
      endcase
    end
    next_q.fault = next_q.fault | set_f;
    next_q.pend = next_q.pend | set_p;
    next_q.io_cycle = i_io_cycle;
    next_q.own_bus = i_own_bus;
    next_q.clk_out = ~q.clk_out;
    if (!master_reset_n_n) begin
      next_q.pend = `IFCAP_ZERO16;
    end
    // console sets status after any clear, set wins
    if (con) begin
      next_q.stat[`IFCAP_STAT_CONSOLE] = 1'b1;
    end
    if (!master_reset_n_n && con && emu) begin
      next_q.maint = 1'b1;
    end
    next_q.oe = test_n;
    next_q.rdata = `IFCAP_ZERO16;
    if (i_rd) begin
      case (i_addr)
        `IFCAP_REG_FAULT: next_q.rdata = q.fault;
        `IFCAP_REG_PEND: next_q.rdata = q.pend;
        `IFCAP_REG_MASK: next_q.rdata = q.mask;
        `IFCAP_REG_STAT: next_q.rdata = q.stat;
        default: next_q.rdata = `IFCAP_ZERO16;
      endcase
    end
    next_q.level = top_level(q.pend & unmask);
    next_q.irq = (next_q.level != `IFCAP_NONE);
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.s1 <= `IFCAP_SYNC_IDLE;
      q.s2 <= `IFCAP_SYNC_IDLE;
      q.prev <= `IFCAP_SYNC_IDLE;
      q.level <= `IFCAP_NONE;
      q.oe <= 1'b1;
    end else begin
      q <= next_q;
    end
  end
  // ==========================================
  // outputs
  assign o_rdata = q.rdata;
  assign o_level = q.level;
  assign o_irq = q.irq;
  assign o_maint_console = q.maint;
  assign bus.io_cycle = q.io_cycle;
  assign bus.own_bus = q.own_bus;
  assign bus.outputs_oe = q.oe;
  assign bus.processor_clock_out = q.clk_out;
endmodule // ifcap_device

// ===== design/ifcap_system.sv
// system end: drives fault, interrupt, reset and test pins
// assumes commands from local system logic on the same clock
`timescale 1ns/10ps
`include "ifcap_cfg.svh"
module ifcap_system #(
  parameter int RST_HOLD = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ifcap_if.sys bus,
  input wire logic i_sys_fault,
  input wire logic i_bus_err,
  input wire logic i_parity,
  input wire logic i_protect,
  input wire logic [5:0] i_user_irq,
  input wire logic [1:0] i_io_irq,
  input wire logic i_power_fail,
  input wire logic i_console,
  input wire logic i_test,
  input wire logic i_emulation,
  input wire logic i_reset_req,
  output logic o_in_reset
);
  import ifcap_pkg::*;
  typedef struct packed {
    ifcap_mode_t mode;
    logic [7:0] cnt;
    logic pf_seen;
    logic [15:0] drv;
    logic master_reset_n_n;
    logic test_n;
    logic in_rst;
  } ifcap_sys_state_t;
  ifcap_sys_state_t q;
  ifcap_sys_state_t next_q;
  // ==========================================
  // reset and test sequencing
  always_comb begin
    next_q = q;
    next_q.drv = {1'b0, i_emulation, i_console, i_power_fail, i_io_irq, i_user_irq,
      i_protect, i_parity, i_bus_err, i_sys_fault};
    if (i_power_fail && !i_emulation) begin
      next_q.pf_seen = 1'b1;
    end
    case (q.mode)
      IFCAP_RUN: begin
        if (i_test || i_reset_req || (q.pf_seen && !i_power_fail)) begin
          next_q.mode = i_test ? IFCAP_TEST : IFCAP_RESET;
          next_q.cnt = 8'(RST_HOLD);
          next_q.pf_seen = 1'b0;
        end
      end
      IFCAP_TEST: begin
        if (!i_test) begin
          next_q.mode = IFCAP_RESET;
          next_q.cnt = 8'(RST_HOLD);
        end
      end
      IFCAP_RESET: begin
        if (i_test) begin
          next_q.mode = IFCAP_TEST;
        end else if (q.cnt != 8'h00) begin
          next_q.cnt = q.cnt - 8'h01;
        end else begin
          next_q.mode = IFCAP_RUN;
        end
      end
      default: next_q.mode = IFCAP_RUN;
    endcase
    next_q.master_reset_n_n = (next_q.mode == IFCAP_RUN);
    next_q.test_n = (next_q.mode != IFCAP_TEST);
    next_q.in_rst = (next_q.mode != IFCAP_RUN);
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.mode <= IFCAP_RESET;
      q.cnt <= 8'(RST_HOLD);
      q.test_n <= 1'b1;
      q.in_rst <= 1'b1;
    end else begin
      q <= next_q;
    end
  end
  // ==========================================
  // pins, fault levels follow the sources and release
  assign bus.system_fault_in = q.drv[`IFCAP_SYN_SYS];
  assign bus.bus_time_error_n = ~q.drv[`IFCAP_SYN_BTE];
  assign bus.mem_parity_err_in = q.drv[`IFCAP_SYN_PAR];
  assign bus.mem_protect_fault_in = q.drv[`IFCAP_SYN_PROT];
  assign bus.user_irq_n = ~q.drv[`IFCAP_SYN_USR +: `IFCAP_N_USER];
  assign bus.io_level_irq_n = ~q.drv[`IFCAP_SYN_IOL +: `IFCAP_N_IOL];
  assign bus.power_fail_n = ~q.drv[`IFCAP_SYN_PWR];
  assign bus.console_in = q.drv[`IFCAP_SYN_CON];
  assign bus.emulation_mode_sel = q.drv[`IFCAP_DRV_EMU];
  assign bus.master_reset_n = q.master_reset_n_n;
  assign bus.test_n = q.test_n;
  assign o_in_reset = q.in_rst;
endmodule // ifcap_system

// ===== bench/ifcap_chk.sv
// pin checker for the interrupt and fault capture pair
// assumes instantiation beside the interface, one clock
`timescale 1ns/10ps
module ifcap_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic system_fault_in,
  input wire logic bus_time_error_n,
  input wire logic mem_parity_err_in,
  input wire logic power_fail_n,
  input wire logic master_reset_n,
  input wire logic test_n,
  input wire logic emulation_mode_sel,
  input wire logic outputs_oe,
  input wire logic processor_clock_out
);
  localparam int HOLD_MAX = 500;
  logic [9:0] flt_cnt;
  logic [9:0] lvl_cnt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // held-fault counters
  always_ff @(posedge i_ref_clk) begin
    flt_cnt <= (!i_rst_n || !system_fault_in) ? 10'h000 : flt_cnt + 10'h001;
    lvl_cnt <= (!i_rst_n || (bus_time_error_n && !mem_parity_err_in)) ? 10'h000 : lvl_cnt + 10'h001;
  end
  // ==========================================
  // sequences and properties
  sequence s_rst_held;
    !master_reset_n [*2];
  endsequence
  sequence s_test_on;
    !test_n [*6];
  endsequence
  property p_test_float; $fell(test_n) |-> ##[1:4] !outputs_oe; endproperty
  property p_test_level; s_test_on |-> !outputs_oe; endproperty
  property p_clk_runs; !test_n ##1 !test_n |-> processor_clock_out != $past(processor_clock_out); endproperty
  property p_rst_width; $fell(master_reset_n) |-> s_rst_held; endproperty
  property p_test_rst; $rose(test_n) |-> ##[0:1] (!master_reset_n [*3]); endproperty
  property p_flt_bound; flt_cnt < HOLD_MAX; endproperty
  property p_lvl_bound; lvl_cnt < HOLD_MAX; endproperty
  property p_pwr_reset; $fell(power_fail_n) && !emulation_mode_sel |-> ##[1:300] !master_reset_n; endproperty
  a_test_float: assert property (p_test_float) else $error("outputs still driven in test");
  a_test_level: assert property (p_test_level) else $error("outputs driven during test");
  a_clk_runs: assert property (p_clk_runs) else $error("processor clock stopped in test");
  a_rst_width: assert property (p_rst_width) else $error("master reset too short");
  a_test_rst: assert property (p_test_rst) else $error("no master reset after test");
  a_flt_bound: assert property (p_flt_bound) else $error("system fault held too long");
  a_lvl_bound: assert property (p_lvl_bound) else $error("bus or parity error held too long");
  a_pwr_reset: assert property (p_pwr_reset) else $error("no master reset after power fail");
endmodule // ifcap_chk

// ===== bench/testbench.sv
// bench joining both ends through the pin interface
// assumes ifcap_cfg.svh on the include path, 10 MHz clock
`timescale 1ns/10ps
`include "ifcap_cfg.svh"
module testbench;
  import ifcap_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic io_cyc = 1'b0;
  logic own = 1'b0;
  logic emu = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  ifcap_addr_t addr = 2'h0;
  ifcap_word_t wdata = 16'h0000;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] rdata;
  logic [4:0] level;
  logic irq;
  logic maint;
  logic in_rst;
  int err_total = 0;
  int comparisons = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  // ==========================================
  // instances
  ifcap_if i_ifcap_if ();
  ifcap_device i_ifcap_device (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(i_ifcap_if.dev),
    .i_io_cycle(io_cyc), .i_own_bus(own), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb),
    .i_rd(rd_stb), .o_rdata(rdata), .o_level(level), .o_irq(irq), .o_maint_console(maint));
  ifcap_system #(.RST_HOLD(2)) i_ifcap_system (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .bus(i_ifcap_if.sys), .i_sys_fault(cmd[0]), .i_bus_err(cmd[1]), .i_parity(cmd[2]),
    .i_protect(cmd[3]), .i_power_fail(cmd[4]), .i_console(cmd[5]), .i_test(cmd[6]),
    .i_reset_req(cmd[7]), .i_user_irq(cmd[13:8]), .i_io_irq(cmd[15:14]), .i_emulation(emu),
    .o_in_reset(in_rst));
  ifcap_chk i_ifcap_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .system_fault_in(i_ifcap_if.system_fault_in), .bus_time_error_n(i_ifcap_if.bus_time_error_n),
    .mem_parity_err_in(i_ifcap_if.mem_parity_err_in), .power_fail_n(i_ifcap_if.power_fail_n),
    .master_reset_n(i_ifcap_if.master_reset_n), .test_n(i_ifcap_if.test_n),
    .emulation_mode_sel(i_ifcap_if.emulation_mode_sel), .outputs_oe(i_ifcap_if.outputs_oe),
    .processor_clock_out(i_ifcap_if.processor_clock_out));
  // ==========================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input ifcap_addr_t a, input ifcap_word_t d);
    @(posedge i_ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input ifcap_addr_t a, input ifcap_word_t e);
    @(posedge i_ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    rd_stb <= 1'b0;
    @(posedge i_ref_clk);
    chk(rdata, e);
  endtask
  task automatic pulse(input logic [15:0] m);
    tick(1);
    cmd <= cmd | m;
    tick(4);
    cmd <= cmd & ~m;
    tick(12);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    tick(30000);
    err_total++;
    wrap_up();
  end
  initial begin
    tick(4);
    i_rst_n <= 1'b1;
    tick(12);
    for (int k = 0; k < 4; k++) rd(ifcap_addr_t'(k), 16'h0000);
    chk({11'h000, level}, 16'h0010);
    wr(`IFCAP_REG_MASK, 16'h0000);
    for (int k = 0; k < 8; k++) pulse(16'h0100 << k);
    rd(`IFCAP_REG_PEND, 16'h00ff);
    wr(`IFCAP_REG_MASK, 16'h00fe);
    tick(3);
    chk({10'h000, level, irq}, 16'h0001);
    wr(`IFCAP_REG_MASK, 16'hffff);
    tick(3);
    chk({10'h000, level, irq}, 16'h0020);
    emu <= 1'b1;
    pulse(16'h0010);
    rd(`IFCAP_REG_PEND, 16'h80ff);
    chk({10'h000, level, irq}, 16'h001f);
    cmd <= cmd | 16'h0020;
    pulse(16'h0080);
    chk({15'h0000, maint}, 16'h0001);
    rd(`IFCAP_REG_PEND, 16'h0000);
    rd(`IFCAP_REG_STAT, 16'h0008);
    cmd <= cmd & ~16'h0020;
    tick(8);
    wr(`IFCAP_REG_STAT, 16'hffff);
    rd(`IFCAP_REG_STAT, 16'h0000);
    emu <= 1'b0;
    pulse(16'h0100);
    pulse(16'h0010);
    tick(100);
    rd(`IFCAP_REG_PEND, 16'h0000);
    io_cyc <= 1'b1;
    pulse(16'h0002);
    io_cyc <= 1'b0;
    pulse(16'h0002);
    pulse(16'h0001);
    own <= 1'b1;
    pulse(16'h0008);
    own <= 1'b0;
    cmd <= cmd | 16'h000c;
    tick(12);
    rd(`IFCAP_REG_FAULT, 16'he580);
    wr(`IFCAP_REG_FAULT, 16'hffff);
    rd(`IFCAP_REG_FAULT, 16'h6000);
    cmd <= cmd & ~16'h000c;
    tick(12);
    wr(`IFCAP_REG_FAULT, 16'hffff);
    rd(`IFCAP_REG_FAULT, 16'h0000);
    cmd <= cmd | 16'h0040;
    tick(8);
    chk({15'h0000, i_ifcap_if.outputs_oe}, 16'h0000);
    chk({15'h0000, in_rst}, 16'h0001);
    cmd <= cmd & ~16'h0040;
    tick(20);
    chk({15'h0000, in_rst}, 16'h0000);
    chk({15'h0000, i_ifcap_if.outputs_oe}, 16'h0001);
    wrap_up();
  end
endmodule // testbench
